// ### rtl/oam_frame_loss_measurement.v
// oam endpoint engine: single and dual ended frame loss measurement
//
// Summary of operation
// [RULE1] one loss counter set serves both measurement types; one active at a time
// [RULE2] no mode select; the transmitted loss pdus decide the measurement type
// [RULE3] every loss pdu samples counters picked by its class of service index
// [RULE4] synthetic mismatch pdus only set their own receive flag
// [RULE5] per-type hw enables; when off only statistics update, pdu unchanged
// [RULE6] per-type bits gate pdu counters and inclusion in data loss counters
// [RULE7] tx lmm: write tx count into TxFCf, bump tx lmm counter
// [RULE8] rx lmm: set lmm flag, write rx count into RxFCf
// [RULE9] loopback and lmm hw enabled: each valid rx lmm injects an lmr through tx lookup
// [RULE10] rx lmm bumps rx lmm counter; optional copy to cpu
// [RULE11] tx lmr: write tx count into TxFCb, bump tx lmr counter
// [RULE12] rx lmr: set lmr flag, sample rx count as RxFCb
// [RULE13] insert option: tlv offset 12 becomes 16, RxFCb written after TxFCb
// [RULE14] insert option zeroes end tlv byte; otherwise RxFCb is not exposed
// [RULE15] rx lmr bumps rx lmr counter; optional copy to cpu
// [RULE16] software keeps continuity check processing on for dual-ended loss
// [RULE17] cc loss hw off: plain ccm handling but cc loss rx flag still set
// [RULE18] one bit gates pdu counting of cc loss pdus, another data counting
// [RULE19] valid ccm with any nonzero loss field is classified as cc loss
// [RULE20] insert-next bit classifies next valid ccm as cc loss; timer may set it
// [RULE21] tx cc loss pdu: write tx count into TxFCf
// [RULE22] insert-next clears itself once a ccm has been classified
`timescale 1ns/10ps
`default_nettype none
`include "oam_loss_consts.vh"
module oam_frame_loss_measurement (
  // clock and reset
  input wire mclk_in,
  input wire rstn_in,
  // apb slave
  input wire [7:0] paddr_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  // data frames counted by the loss counters
  input wire data_tx_in,
  input wire [2:0] data_tx_cos_in,
  input wire data_rx_in,
  input wire [2:0] data_rx_cos_in,
  // pdu lookup request from the frame pipeline
  input wire lookup_valid_in,
  input wire lookup_rx_in,
  input wire [2:0] lookup_type_in,
  input wire [2:0] lookup_cos_in,
  input wire lookup_pdu_ok_in,
  input wire lookup_lm_nonzero_in,
  // continuity timer request for cc loss insertion
  input wire insert_next_set_in,
  // lookup result
  output wire result_valid_out,
  output wire result_ccm_lm_out,
  output wire cpu_copy_out,
  output wire inject_lmr_out,
  output wire field_wr_out,
  output wire [1:0] field_sel_out,
  output wire [31:0] field_value_out,
  output wire tlv_offset_wr_out,
  output wire [7:0] tlv_offset_out,
  output wire end_tlv_zero_out,
  output wire insert_next_out
);
  // registers
  reg [`CTRL_WIDTH-1:0] ctrl_q;
  reg [`STK_WIDTH-1:0] sticky_q;
  reg [`STK_WIDTH-1:0] sticky_d;
  reg insert_next_q;
  reg insert_next_d;
  reg [31:0] lmm_tx_cnt_q;
  reg [31:0] lmm_rx_cnt_q;
  reg [31:0] lmr_tx_cnt_q;
  reg [31:0] lmr_rx_cnt_q;
  reg [2:0] cnt_sel_q;
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg [31:0] rd_d;
  reg hit_d;
  // result registers
  reg res_valid_q;
  reg res_ccm_lm_q;
  reg cpu_copy_q;
  reg inject_q;
  reg field_wr_q;
  reg [1:0] field_sel_q;
  reg [31:0] field_value_q;
  reg tlv_wr_q;
  reg end_tlv_q;
  reg [7:0] tlv_ofs_q;
  reg field_wr_d;
  reg [1:0] field_sel_d;
  reg [31:0] field_value_d;
  wire [31:0] tx_smp;
  wire [31:0] rx_smp;
  wire [31:0] tx_rd;
  wire [31:0] rx_rd;

  // apb phases
  wire setup = psel_in && !penable_in;
  wire wr_en = psel_in && penable_in && pready_q && pwrite_in && !pslverr_q;
  wire wr_sticky = wr_en && (paddr_in == `REG_STICKY);
  wire wr_ccm = wr_en && (paddr_in == `REG_CCM_STAT);

  // control fields
  wire synth = ctrl_q[`CTRL_SYNTH_MODE];
  wire lmm_hw = ctrl_q[`CTRL_LMM_HW];
  wire lmr_hw = ctrl_q[`CTRL_LMR_HW];
  wire cc_hw = ctrl_q[`CTRL_CC_HW];

  // lookup decode
  wire lk = lookup_valid_in && lookup_pdu_ok_in;
  wire rx = lookup_rx_in;
  wire t_lmm = lk && (lookup_type_in == `PDU_LMM);
  wire t_lmr = lk && (lookup_type_in == `PDU_LMR);
  wire t_ccm = lk && (lookup_type_in == `PDU_CCM);
  wire t_slm = lk && (lookup_type_in == `PDU_SLM);
  wire t_slr = lk && (lookup_type_in == `PDU_SLR);
  // [RULE4] full handling only when not in synthetic mode
  wire lmm_f = t_lmm && !synth;
  wire lmr_f = t_lmr && !synth;
  // [RULE19] [RULE20] cc loss classification
  wire cclm = t_ccm && (lookup_lm_nonzero_in || insert_next_q);
  // [RULE17] cc loss functions only with hw enable
  wire cclm_f = cclm && cc_hw;

  // [RULE6] [RULE18] pdus added to data loss counters
  wire pdu_data = (lmm_f && ctrl_q[`CTRL_LMM_DATA_CNT]) ||
                  (lmr_f && ctrl_q[`CTRL_LMR_DATA_CNT]) ||
                  (cclm && ctrl_q[`CTRL_CC_DATA_CNT]);

  // [RULE1] [RULE2] one shared counter set, no type selection
  loss_counter_bank u_bank (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .tx_a_in(data_tx_in),
    .tx_a_cos_in(data_tx_cos_in),
    .tx_b_in(pdu_data && !rx),
    .tx_b_cos_in(lookup_cos_in),
    .rx_a_in(data_rx_in),
    .rx_a_cos_in(data_rx_cos_in),
    .rx_b_in(pdu_data && rx),
    .rx_b_cos_in(lookup_cos_in),
    .smp_cos_in(lookup_cos_in),
    .rd_cos_in(cnt_sel_q),
    .tx_smp_out(tx_smp),
    .rx_smp_out(rx_smp),
    .tx_rd_out(tx_rd),
    .rx_rd_out(rx_rd)
  );

  // apb read mux and address decode
  always @* begin
    rd_d = 32'h00000000;
    hit_d = 1'b1;
    case (paddr_in)
      `REG_CTRL: rd_d = {18'h00000, ctrl_q};
      `REG_STICKY: rd_d = {27'h0000000, sticky_q};
      `REG_CCM_STAT: rd_d = {31'h00000000, insert_next_q};
      `REG_LMM_TX_CNT: rd_d = lmm_tx_cnt_q;
      `REG_LMM_RX_CNT: rd_d = lmm_rx_cnt_q;
      `REG_LMR_TX_CNT: rd_d = lmr_tx_cnt_q;
      `REG_LMR_RX_CNT: rd_d = lmr_rx_cnt_q;
      `REG_CNT_SEL: rd_d = {29'h00000000, cnt_sel_q};
      `REG_TX_LOSS: rd_d = tx_rd;
      `REG_RX_LOSS: rd_d = rx_rd;
      default: hit_d = 1'b0;
    endcase
  end

  // apb answer: ready in the first access cycle
  always @(posedge mclk_in) begin
    if (!rstn_in) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= pwrite_in ? 32'h00000000 : rd_d;
        pslverr_q <= !hit_d;
      end else begin
        prdata_q <= 32'h00000000;
        pslverr_q <= 1'b0;
      end
    end
  end

  // software writable configuration
  always @(posedge mclk_in) begin
    if (!rstn_in) begin
      ctrl_q <= `CTRL_RESET;
      cnt_sel_q <= 3'h0;
    end else if (wr_en) begin
      if (paddr_in == `REG_CTRL)
        ctrl_q <= pwdata_in[`CTRL_WIDTH-1:0];
      if (paddr_in == `REG_CNT_SEL)
        cnt_sel_q <= pwdata_in[2:0];
    end
  end

  // receive flags: write one to clear, a new event wins
  always @* begin
    sticky_d = sticky_q;
    if (wr_sticky)
      sticky_d = sticky_q & ~pwdata_in[`STK_WIDTH-1:0];
    if (rx) begin
      // [RULE8] lmm flag, also on a mismatched engine
      if (t_lmm)
        sticky_d[`STK_LMM] = 1'b1;
      // [RULE12] lmr flag
      if (t_lmr)
        sticky_d[`STK_LMR] = 1'b1;
      // [RULE17] cc loss flag regardless of hw enable
      if (cclm)
        sticky_d[`STK_CCM_LM] = 1'b1;
      // [RULE4] synthetic pdus only raise their flag
      if (t_slm)
        sticky_d[`STK_SLM] = 1'b1;
      if (t_slr)
        sticky_d[`STK_SLR] = 1'b1;
    end
  end

  // insert-next control bit
  always @* begin
    insert_next_d = insert_next_q;
    // [RULE22] self clear once a ccm is converted
    if (t_ccm && insert_next_q)
      insert_next_d = 1'b0;
    if (wr_ccm && !pwdata_in[0])
      insert_next_d = 1'b0;
    // [RULE20] software or the continuity timer sets it
    if ((wr_ccm && pwdata_in[0]) || insert_next_set_in)
      insert_next_d = 1'b1;
  end

  // flag and insert-next state
  always @(posedge mclk_in) begin
    if (!rstn_in) begin
      sticky_q <= 5'h00;
      insert_next_q <= 1'b0;
    end else begin
      sticky_q <= sticky_d;
      insert_next_q <= insert_next_d;
    end
  end

  // pdu statistics counters
  always @(posedge mclk_in) begin
    if (!rstn_in) begin
      lmm_tx_cnt_q <= 32'h00000000;
      lmm_rx_cnt_q <= 32'h00000000;
      lmr_tx_cnt_q <= 32'h00000000;
      lmr_rx_cnt_q <= 32'h00000000;
    end else begin
      // [RULE7] [RULE6] tx lmm count
      if (!rx && ((lmm_f && ctrl_q[`CTRL_LMM_PDU_CNT]) ||
                  (cclm && ctrl_q[`CTRL_CC_PDU_CNT])))
        lmm_tx_cnt_q <= lmm_tx_cnt_q + 32'h00000001;
      // [RULE10] rx lmm count
      if (rx && lmm_f && ctrl_q[`CTRL_LMM_PDU_CNT])
        lmm_rx_cnt_q <= lmm_rx_cnt_q + 32'h00000001;
      // [RULE11] tx lmr count
      if (!rx && lmr_f && ctrl_q[`CTRL_LMR_PDU_CNT])
        lmr_tx_cnt_q <= lmr_tx_cnt_q + 32'h00000001;
      // [RULE15] [RULE18] rx lmr and cc loss count
      if (rx && ((lmr_f && ctrl_q[`CTRL_LMR_PDU_CNT]) ||
                 (cclm && ctrl_q[`CTRL_CC_PDU_CNT])))
        lmr_rx_cnt_q <= lmr_rx_cnt_q + 32'h00000001;
    end
  end

  // pdu field edits, only with the type's hw enable
  always @* begin
    field_wr_d = 1'b0;
    field_sel_d = `FLD_TXFCF;
    field_value_d = 32'h00000000;
    // [RULE3] [RULE5] samples follow the lookup class of service
    if (!rx && lmm_f && lmm_hw) begin
      // [RULE7] TxFCf on tx lmm
      field_wr_d = 1'b1;
      field_value_d = tx_smp;
    end else if (rx && lmm_f && lmm_hw) begin
      // [RULE8] RxFCf on rx lmm
      field_wr_d = 1'b1;
      field_sel_d = `FLD_RXFCF;
      field_value_d = rx_smp;
    end else if (!rx && lmr_f && lmr_hw) begin
      // [RULE11] TxFCb on tx lmr
      field_wr_d = 1'b1;
      field_sel_d = `FLD_TXFCB;
      field_value_d = tx_smp;
    end else if (rx && lmr_f && lmr_hw && ctrl_q[`CTRL_RX_INSERT]) begin
      // [RULE12] [RULE13] sampled RxFCb after TxFCb
      field_wr_d = 1'b1;
      field_sel_d = `FLD_RXFCB;
      field_value_d = rx_smp;
    end else if (!rx && cclm_f) begin
      // [RULE21] TxFCf on tx cc loss
      field_wr_d = 1'b1;
      field_value_d = tx_smp;
    end
  end

  // lookup result registers
  always @(posedge mclk_in) begin
    if (!rstn_in) begin
      res_valid_q <= 1'b0;
      res_ccm_lm_q <= 1'b0;
      cpu_copy_q <= 1'b0;
      inject_q <= 1'b0;
      field_wr_q <= 1'b0;
      field_sel_q <= `FLD_TXFCF;
      field_value_q <= 32'h00000000;
      tlv_wr_q <= 1'b0;
      end_tlv_q <= 1'b0;
      tlv_ofs_q <= `TLV_OFS_STD;
    end else begin
      res_valid_q <= lk;
      res_ccm_lm_q <= cclm_f;
      // [RULE10] [RULE15] cpu copies
      cpu_copy_q <= rx && ((lmm_f && ctrl_q[`CTRL_LMM_CPU]) ||
                           (lmr_f && ctrl_q[`CTRL_LMR_CPU]));
      // [RULE9] loop lmm back as an injected lmr
      inject_q <= rx && lmm_f && lmm_hw && ctrl_q[`CTRL_LOOPBACK];
      field_wr_q <= field_wr_d;
      field_sel_q <= field_sel_d;
      field_value_q <= field_value_d;
      // [RULE13] [RULE14] tlv offset and end tlv with insertion
      tlv_wr_q <= rx && lmr_f && lmr_hw && ctrl_q[`CTRL_RX_INSERT];
      end_tlv_q <= rx && lmr_f && lmr_hw && ctrl_q[`CTRL_RX_INSERT];
      tlv_ofs_q <= (rx && lmr_f && lmr_hw && ctrl_q[`CTRL_RX_INSERT]) ? `TLV_OFS_EXT : `TLV_OFS_STD;
    end
  end

  // outputs straight from flip-flops
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign result_valid_out = res_valid_q;
  assign result_ccm_lm_out = res_ccm_lm_q;
  assign cpu_copy_out = cpu_copy_q;
  assign inject_lmr_out = inject_q;
  assign field_wr_out = field_wr_q;
  assign field_sel_out = field_sel_q;
  assign field_value_out = field_value_q;
  assign tlv_offset_wr_out = tlv_wr_q;
  // new offset only meaningful with tlv_offset_wr_out
  assign tlv_offset_out = tlv_ofs_q;
  assign end_tlv_zero_out = end_tlv_q;
  assign insert_next_out = insert_next_q;
endmodule // oam_frame_loss_measurement
`default_nettype wire

// ### rtl/oam_loss_consts.vh
// constants for the oam frame loss measurement engine
`ifndef OAM_LOSS_CONSTS_VH
`define OAM_LOSS_CONSTS_VH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STICKY 8'h04
`define REG_CCM_STAT 8'h08
`define REG_LMM_TX_CNT 8'h0c
`define REG_LMM_RX_CNT 8'h10
`define REG_LMR_TX_CNT 8'h14
`define REG_LMR_RX_CNT 8'h18
`define REG_CNT_SEL 8'h1c
`define REG_TX_LOSS 8'h20
`define REG_RX_LOSS 8'h24
// control register bits
`define CTRL_LMM_HW 0
`define CTRL_LMR_HW 1
`define CTRL_CC_HW 2
`define CTRL_LMM_PDU_CNT 3
`define CTRL_LMR_PDU_CNT 4
`define CTRL_CC_PDU_CNT 5
`define CTRL_LMM_DATA_CNT 6
`define CTRL_LMR_DATA_CNT 7
`define CTRL_CC_DATA_CNT 8
`define CTRL_LOOPBACK 9
`define CTRL_LMM_CPU 10
`define CTRL_LMR_CPU 11
`define CTRL_RX_INSERT 12
`define CTRL_SYNTH_MODE 13
`define CTRL_WIDTH 14
`define CTRL_RESET 14'h0000
// sticky register bits
`define STK_LMM 0
`define STK_LMR 1
`define STK_CCM_LM 2
`define STK_SLM 3
`define STK_SLR 4
`define STK_WIDTH 5
// pdu type codes on the lookup port
`define PDU_OTHER 3'h0
`define PDU_LMM 3'h1
`define PDU_LMR 3'h2
`define PDU_CCM 3'h3
`define PDU_SLM 3'h4
`define PDU_SLR 3'h5
// field select codes on the edit port
`define FLD_TXFCF 2'h0
`define FLD_RXFCF 2'h1
`define FLD_TXFCB 2'h2
`define FLD_RXFCB 2'h3
// tlv offset values
`define TLV_OFS_STD 8'h0c
`define TLV_OFS_EXT 8'h10
`define NUM_COS 8
`endif

// ### rtl/loss_counter_bank.v
// per class-of-service tx and rx frame loss counters
`timescale 1ns/10ps
`default_nettype none
module loss_counter_bank (
  // clock and reset
  input wire mclk_in,
  input wire rstn_in,
  // increment events (a: data frame, b: counted pdu)
  input wire tx_a_in,
  input wire [2:0] tx_a_cos_in,
  input wire tx_b_in,
  input wire [2:0] tx_b_cos_in,
  input wire rx_a_in,
  input wire [2:0] rx_a_cos_in,
  input wire rx_b_in,
  input wire [2:0] rx_b_cos_in,
  // read selects and values
  input wire [2:0] smp_cos_in,
  input wire [2:0] rd_cos_in,
  output wire [31:0] tx_smp_out,
  output wire [31:0] rx_smp_out,
  output wire [31:0] tx_rd_out,
  output wire [31:0] rx_rd_out
);
  reg [31:0] tx_q [0:7];
  reg [31:0] rx_q [0:7];
  genvar i;
  // one counter pair per class of service
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_cos
      wire [1:0] tx_add = {1'b0, tx_a_in && (tx_a_cos_in == i)} +
                          {1'b0, tx_b_in && (tx_b_cos_in == i)};
      wire [1:0] rx_add = {1'b0, rx_a_in && (rx_a_cos_in == i)} +
                          {1'b0, rx_b_in && (rx_b_cos_in == i)};
      always @(posedge mclk_in) begin
        if (!rstn_in) begin
          tx_q[i] <= 32'h00000000;
          rx_q[i] <= 32'h00000000;
        end else begin
          tx_q[i] <= tx_q[i] + {30'h00000000, tx_add};
          rx_q[i] <= rx_q[i] + {30'h00000000, rx_add};
        end
      end
    end
  endgenerate
  // values before this cycle's increments
  assign tx_smp_out = tx_q[smp_cos_in];
  assign rx_smp_out = rx_q[smp_cos_in];
  assign tx_rd_out = tx_q[rd_cos_in];
  assign rx_rd_out = rx_q[rd_cos_in];
endmodule // loss_counter_bank
`default_nettype wire

// ### dv/oam_loss_props.sv
// port assertions for the frame loss engine
`timescale 1ns/10ps
`default_nettype none
`include "oam_loss_consts.vh"
module oam_loss_props (
  // clock, reset and requests
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic lookup_valid_in,
  input wire logic lookup_rx_in,
  input wire logic [2:0] lookup_type_in,
  input wire logic lookup_pdu_ok_in,
  input wire logic insert_next_set_in,
  input wire logic psel_in,
  // lookup results
  input wire logic result_valid_out,
  input wire logic result_ccm_lm_out,
  input wire logic inject_lmr_out,
  input wire logic field_wr_out,
  input wire logic [1:0] field_sel_out,
  input wire logic tlv_offset_wr_out,
  input wire logic [7:0] tlv_offset_out,
  input wire logic end_tlv_zero_out,
  input wire logic insert_next_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // one valid lookup this cycle
  wire lk = lookup_valid_in && lookup_pdu_ok_in;
  wire ccm = lk && lookup_type_in == `PDU_CCM;
  a_result_timing: assert property ($past(lk) == result_valid_out)
    else $error("result not one cycle after lookup");
  a_txfcf_cause: assert property (field_wr_out && field_sel_out == `FLD_TXFCF |->
    $past(lk && !lookup_rx_in)) else $error("TxFCf write without tx lookup");
  a_rxfcf_cause: assert property (field_wr_out && field_sel_out == `FLD_RXFCF |->
    $past(lk && lookup_rx_in && lookup_type_in == `PDU_LMM)) else $error("bad RxFCf write");
  a_txfcb_cause: assert property (field_wr_out && field_sel_out == `FLD_TXFCB |->
    $past(lk && !lookup_rx_in && lookup_type_in == `PDU_LMR)) else $error("bad TxFCb write");
  a_inject_cause: assert property (inject_lmr_out |->
    $past(lk && lookup_rx_in && lookup_type_in == `PDU_LMM)) else $error("stray reply inject");
  a_insert_format: assert property (tlv_offset_wr_out |->
    tlv_offset_out == `TLV_OFS_EXT && end_tlv_zero_out && field_sel_out == `FLD_RXFCB)
    else $error("bad count insert format");
  a_std_offset: assert property (!tlv_offset_wr_out |->
    tlv_offset_out == `TLV_OFS_STD && !end_tlv_zero_out) else $error("offset altered");
  a_ccm_class: assert property (result_ccm_lm_out |-> $past(ccm))
    else $error("cc loss without ccm lookup");
  a_insert_set: assert property (insert_next_set_in |=> insert_next_out)
    else $error("insert-next not set");
  a_insert_clear: assert property (ccm && !insert_next_set_in && !psel_in |=>
    !insert_next_out) else $error("insert-next not cleared");
endmodule // oam_loss_props
bind oam_frame_loss_measurement oam_loss_props props_u (.*);
`default_nettype wire

// ### dv/oam_peer_pipe.sv
// frame pipeline model: passes lookups and returns looped replies
`timescale 1ns/10ps
`default_nettype none
`include "oam_loss_consts.vh"
module oam_peer_pipe (
  // clock and bench requests
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic req_in,
  input wire logic req_rx_in,
  input wire logic [2:0] req_type_in,
  input wire logic [2:0] req_cos_in,
  input wire logic req_nz_in,
  input wire logic inject_in,
  // lookup toward the engine
  output logic lk_valid_out,
  output logic lk_rx_out,
  output logic [2:0] lk_type_out,
  output logic [2:0] lk_cos_out,
  output logic lk_nz_out,
  output logic lk_ok_out
);
  logic inj_q = 1'b0;
  logic [2:0] cos_q = 3'h0;
  // injected reply re-enters through the tx lookup
  always @(posedge mclk_in) begin
    inj_q <= rstn_in & inject_in;
    if (req_in)
      cos_q <= req_cos_in;
  end
  assign lk_valid_out = req_in | inj_q;
  assign lk_ok_out = 1'b1;
  assign lk_rx_out = inj_q ? 1'b0 : req_rx_in;
  assign lk_type_out = inj_q ? `PDU_LMR : req_type_in;
  assign lk_cos_out = inj_q ? cos_q : req_cos_in;
  assign lk_nz_out = !inj_q && req_nz_in;
endmodule // oam_peer_pipe
`default_nettype wire

// ### dv/tb_oam_frame_loss_measurement.sv
// self-checking bench for the frame loss engine
`timescale 1ns/10ps
`default_nettype none
`include "oam_loss_consts.vh"
module tb_oam_frame_loss_measurement;
  // stimulus, outputs and model state
  logic mclk_in = 1'b0, rstn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic data_tx_in = 1'b0, data_rx_in = 1'b0, insert_next_set_in = 1'b0, req = 1'b0;
  logic rrx = 1'b0, rnz = 1'b0, err, insm = 1'b0;
  logic [2:0] data_tx_cos_in = '0, data_rx_cos_in = '0, rty = '0, rco = '0;
  logic [7:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, s = 32'h8, rd, r;
  logic [13:0] ctrl = '0;
  logic [4:0] flg = '0;
  int txc[8], rxc[8], pc[4], n_errors, comparisons, cyc;
  wire [31:0] prdata_out, field_value_out;
  wire [7:0] tlv_offset_out;
  wire [2:0] lookup_type_in, lookup_cos_in;
  wire [1:0] field_sel_out;
  wire pready_out, pslverr_out, lookup_valid_in, lookup_rx_in, lookup_pdu_ok_in;
  wire lookup_lm_nonzero_in, result_valid_out, result_ccm_lm_out, cpu_copy_out;
  wire inject_lmr_out, field_wr_out, tlv_offset_wr_out, end_tlv_zero_out, insert_next_out;
  oam_peer_pipe peer_u (.mclk_in, .rstn_in, .req_in(req), .req_rx_in(rrx), .req_type_in(rty),
    .req_cos_in(rco), .req_nz_in(rnz), .inject_in(inject_lmr_out), .lk_valid_out(lookup_valid_in),
    .lk_rx_out(lookup_rx_in), .lk_type_out(lookup_type_in), .lk_cos_out(lookup_cos_in),
    .lk_nz_out(lookup_lm_nonzero_in), .lk_ok_out(lookup_pdu_ok_in));
  oam_frame_loss_measurement dut_u (.*);
  always #2 mclk_in = ~mclk_in;
  // cut a hang short
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task chk(input logic [31:0] a, input logic [31:0] e);
    comparisons++;
    if (a !== e) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, a, e);
    end
  endtask
  // one apb transfer, held until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // answer taken at the edge where pready is sampled high
    @(posedge mclk_in);
    while (pready_out !== 1'b1) @(posedge mclk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task wc(input logic [13:0] v);
    apb(1'b1, `REG_CTRL, {18'h0, v});
    ctrl = v;
  endtask
  task frm(input logic d, input logic [2:0] c);
    @(posedge mclk_in);
    data_tx_in <= d;
    data_rx_in <= !d;
    data_tx_cos_in <= c;
    data_rx_cos_in <= c;
    if (d) txc[c]++;
    else rxc[c]++;
    @(posedge mclk_in);
    data_tx_in <= 1'b0;
    data_rx_in <= 1'b0;
  endtask
  // one lookup with its model outcome
  task lk(input logic rx, input logic [2:0] ty, input logic [2:0] co, input logic nz);
    logic w, cl, cp, ij, tw;
    logic [1:0] sl;
    logic [2:0] ts;
    logic [31:0] v;
    {w, cp, ij, tw, sl, v} = '0;
    cl = ty == `PDU_CCM && (nz || insm);
    // synthetic mode leaves lmm and lmr with their receive flag only
    ts = (ctrl[13] && (ty == `PDU_LMM || ty == `PDU_LMR)) ? `PDU_OTHER : ty;
    if (rx && ty == `PDU_LMM) flg[0] = 1'b1;
    if (rx && ty == `PDU_LMR) flg[1] = 1'b1;
    case ({rx, ts})
      {1'b0, `PDU_LMM}: begin
        {w, sl, v} = {ctrl[0], `FLD_TXFCF, txc[co]};
        if (ctrl[3]) pc[0]++;
        if (ctrl[6]) txc[co]++;
      end
      {1'b1, `PDU_LMM}: begin
        {w, sl, v, ij, cp} = {ctrl[0], `FLD_RXFCF, rxc[co], ctrl[0] & ctrl[9], ctrl[10]};
        if (ctrl[3]) pc[1]++;
        if (ctrl[6]) rxc[co]++;
      end
      {1'b0, `PDU_LMR}: begin
        {w, sl, v} = {ctrl[1], `FLD_TXFCB, txc[co]};
        if (ctrl[4]) pc[2]++;
        if (ctrl[7]) txc[co]++;
      end
      {1'b1, `PDU_LMR}: begin
        tw = ctrl[1] & ctrl[12];
        {w, sl, v, cp} = {tw, `FLD_RXFCB, rxc[co], ctrl[11]};
        if (ctrl[4]) pc[3]++;
        if (ctrl[7]) rxc[co]++;
      end
      {1'b0, `PDU_CCM}: begin
        {w, sl, v} = {cl & ctrl[2], `FLD_TXFCF, txc[co]};
        if (cl & ctrl[5]) pc[0]++;
        if (cl & ctrl[8]) txc[co]++;
      end
      {1'b1, `PDU_CCM}: begin
        flg[2] = flg[2] | cl;
        if (cl & ctrl[5]) pc[3]++;
        if (cl & ctrl[8]) rxc[co]++;
      end
      {1'b1, `PDU_SLM}: flg[3] = 1'b1;
      {1'b1, `PDU_SLR}: flg[4] = 1'b1;
      default: ;
    endcase
    if (ty == `PDU_CCM) insm = 1'b0;
    @(posedge mclk_in);
    req <= 1'b1;
    rrx <= rx;
    rty <= ty;
    rco <= co;
    rnz <= nz;
    @(posedge mclk_in);
    req <= 1'b0;
    #1;
    chk({result_valid_out, result_ccm_lm_out, cpu_copy_out}, {1'b1, cl & ctrl[2], cp});
    if (!(rx && ty == `PDU_CCM))
      chk({field_wr_out, field_sel_out & {2{w}}}, {w, sl & {2{w}}});
    chk(field_value_out, w ? v : 32'h0);
    chk({inject_lmr_out, tlv_offset_wr_out, end_tlv_zero_out, tlv_offset_out},
      {ij, tw, tw, tw ? `TLV_OFS_EXT : `TLV_OFS_STD});
    chk(insert_next_out, insm);
    if (ij) begin
      repeat (2) @(posedge mclk_in);
      #1;
      chk({result_valid_out, field_wr_out, field_sel_out}, {2'h3, `FLD_TXFCB});
      chk(field_value_out, txc[co]);
      if (ctrl[4]) pc[2]++;
      if (ctrl[7]) txc[co]++;
    end
  endtask
  task cnts;
    for (int i = 0; i < 4; i++) rdc(`REG_LMM_TX_CNT + 8'(4 * i), pc[i]);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `REG_CNT_SEL, i);
      rdc(`REG_TX_LOSS, txc[i]);
      rdc(`REG_RX_LOSS, rxc[i]);
    end
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge mclk_in);
    rstn_in <= 1'b1;
    for (int a = 0; a < 40; a += 4) rdc(8'(a), 32'h0);
    apb(1'b1, 8'h40, 32'hffffffff);
    chk(err, 1'b1);
    $display("test 1 done");
    repeat (24) begin
      r = xs();
      frm(r[0], r[3:1]);
    end
    // all edits, copies and loopback on, every count but the cc pdu count
    wc(14'h1fdf);
    repeat (16) begin
      r = xs();
      lk(r[0], r[1] ? `PDU_LMR : `PDU_LMM, r[4:2], 1'b0);
    end
    apb(1'b1, `REG_LMM_TX_CNT, 32'h5);
    cnts;
    rdc(`REG_STICKY, flg);
    $display("test 2 done");
    wc(14'h00d8);
    lk(1'b0, `PDU_LMM, 3'h2, 1'b0);
    lk(1'b1, `PDU_LMR, 3'h5, 1'b0);
    cnts;
    $display("test 3 done");
    wc(14'h0124);
    lk(1'b0, `PDU_CCM, 3'h1, 1'b1);
    lk(1'b0, `PDU_CCM, 3'h2, 1'b0);
    apb(1'b1, `REG_CCM_STAT, 32'h1);
    insm = 1'b1;
    rdc(`REG_CCM_STAT, 32'h1);
    lk(1'b0, `PDU_CCM, 3'h3, 1'b0);
    @(posedge mclk_in);
    insert_next_set_in <= 1'b1;
    insm = 1'b1;
    @(posedge mclk_in);
    insert_next_set_in <= 1'b0;
    lk(1'b1, `PDU_CCM, 3'h4, 1'b0);
    cnts;
    wc(14'h0000);
    apb(1'b1, `REG_STICKY, 32'h1f);
    flg = '0;
    lk(1'b1, `PDU_CCM, 3'h5, 1'b1);
    lk(1'b1, `PDU_SLM, 3'h6, 1'b0);
    lk(1'b1, `PDU_SLR, 3'h7, 1'b0);
    // synthetic mode: loss pdus only raise their flag
    wc(14'h2203);
    lk(1'b1, `PDU_LMM, 3'h0, 1'b0);
    lk(1'b0, `PDU_LMR, 3'h1, 1'b0);
    rdc(`REG_STICKY, flg);
    $display("test 4 done");
    complete_run;
  end
endmodule // tb_oam_frame_loss_measurement
`default_nettype wire
